// ---- core/icp_consts.svh ----
// register offsets, field positions and reset values of the interrupt block
`ifndef ICP_CONSTS_SVH
`define ICP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ICP_OFS_EN0      8'ha8
`define ICP_OFS_EN1      8'ha9
`define ICP_OFS_EN2      8'haa
`define ICP_OFS_EN3      8'hab
`define ICP_OFS_PEND     8'hac
`define ICP_OFS_SENSE    8'had
`define ICP_OFS_POLA     8'hae
`define ICP_OFS_PINEN    8'haf
`define ICP_OFS_PRIO_LO  8'hb8
`define ICP_OFS_PRIO_HI  8'hf8
`define ICP_OFS_STAT     8'hb0
`define ICP_OFS_MASK     8'hb1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ICP_RST_BYTE     8'h00
`define ICP_RST_STAT     4'h0

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ICP_GLOBAL_BIT   7
`define ICP_EN0_RW_MASK  8'hbf
`define ICP_LOW6_MASK    8'h3f
`define ICP_EXT_MASK     8'h03
// sources that really exist: ext0/1, timer0/1, converter, watchdog, interval
`define ICP_SRC_MASK     24'h646006
`define ICP_NUM_EXT0     5'h01
`define ICP_NUM_EXT1     5'h02
// status bits: ext0 set, ext1 set, vector taken, service returned
`define ICP_ST_EXT0      0
`define ICP_ST_EXT1      1
`define ICP_ST_TAKEN     2
`define ICP_ST_RET       3

`endif

// ---- core/icp_pkg.sv ----
// types shared by the interrupt enable and priority block
package icp_pkg;

	// ----------------------------------------------------------------
	// register port request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} icp_bus_type;

	typedef logic [1:0] icp_level_type;

	// request presented to the core
	typedef struct packed {
		logic          valid;
		logic [4:0]    num;
		icp_level_type level;
	} icp_vec_type;

endpackage : icp_pkg

// ---- core/icp_ctrl.sv ----
// interrupt enable, priority and external interrupt logic
// Function
// R01: global enable bit gates every maskable source
// R02: enable 0 bit2 ext1, bit1 ext0
// R03: enable 2 bit2 timer1, bit1 timer0
// R04: enable 3 interval, watchdog, converter bits
// R05: enable 1 gates no source
// R06: two-bit group level from two registers
// R07: pending flag sets on condition, zero-write clears
// R08: sense bit zero level, one edge
// R09: level mode: polarity picks high or low
// R10: edge mode: polarity picks rising or falling
// R11: pin enable bit gates external interrupt
// R12: taken vector clears its external pending flag
// R13: six groups of four consecutive sources
// R14: equal level: lower number wins
// R15: preempt only by strictly higher level
// R16: external pins synchronised before detection
// R17: request needs global, source enable, pending
//
// Implementation choice: the address-and-strobe port.
`include "icp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module icp_ctrl (
	input  wire logic                ref_clk,    // 40 MHz system clock
	input  wire logic                rst,        // async reset, high
	input  wire icp_pkg::icp_bus_type bus_req,   // register port request
	output var  logic [7:0]          bus_rdata,  // read data, next cycle
	input  wire logic [1:0]          ext_pin,    // external interrupt pins
	input  wire logic [23:0]         periph_req, // peripheral requests
	input  wire logic                irq_ack,    // core takes the vector
	input  wire logic                irq_ret,    // core ends a service
	output var  icp_pkg::icp_vec_type irq_vec,   // request to the core
	output var  logic                sys_irq     // unmasked status event
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic icp_pkg::icp_level_type lvl_of(
		input logic [4:0] n, input logic [7:0] lo, input logic [7:0] hi);
		logic [2:0] g;
		g = n[4:2]; // R13
		return {hi[g], lo[g]}; // R06
	endfunction : lvl_of

	function automatic logic [2:0] top_lvl(input logic [3:0] s);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				r = {1'b1, 2'(k)};
			end
		end
		return r;
	endfunction : top_lvl

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] en0_r, en1_r, en2_r, en3_r;
	logic [7:0] prio_lo_r, prio_hi_r;
	logic [7:0] sense_r, pola_r, pinen_r;
	logic [1:0] pend_r, pend_nxt;
	logic [3:0] stat_r, mask_r, stat_set;
	logic [3:0] svc_r;
	logic [1:0] ext_s1, ext_s2, ext_s3;
	logic [1:0] cond, set_ext;
	logic       wr_en0, wr_en1, wr_en2, wr_en3, wr_lo, wr_hi;
	logic       wr_pend, wr_sense, wr_pola, wr_pinen, wr_stat, wr_mask;
	logic [23:0] en_vec, req_vec, pend_vec;
	logic        best_any;
	logic [4:0]  best_num;
	icp_pkg::icp_level_type best_lvl;
	logic [2:0]  cur;
	logic        may_req;
	logic [1:0]  ack_clr;

	assign wr_en0   = bus_req.wr && bus_req.addr == `ICP_OFS_EN0;
	assign wr_en1   = bus_req.wr && bus_req.addr == `ICP_OFS_EN1;
	assign wr_en2   = bus_req.wr && bus_req.addr == `ICP_OFS_EN2;
	assign wr_en3   = bus_req.wr && bus_req.addr == `ICP_OFS_EN3;
	assign wr_lo    = bus_req.wr && bus_req.addr == `ICP_OFS_PRIO_LO;
	assign wr_hi    = bus_req.wr && bus_req.addr == `ICP_OFS_PRIO_HI;
	assign wr_pend  = bus_req.wr && bus_req.addr == `ICP_OFS_PEND;
	assign wr_sense = bus_req.wr && bus_req.addr == `ICP_OFS_SENSE;
	assign wr_pola  = bus_req.wr && bus_req.addr == `ICP_OFS_POLA;
	assign wr_pinen = bus_req.wr && bus_req.addr == `ICP_OFS_PINEN;
	assign wr_stat  = bus_req.wr && bus_req.addr == `ICP_OFS_STAT;
	assign wr_mask  = bus_req.wr && bus_req.addr == `ICP_OFS_MASK;

	// bits 6 and 7 read zero, except global bit 7 of enable 0; bits of absent sources keep their value but reach no source
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			en0_r <= `ICP_RST_BYTE;
			en1_r <= `ICP_RST_BYTE;
			en2_r <= `ICP_RST_BYTE;
			en3_r <= `ICP_RST_BYTE;
		end else begin
			if (wr_en0) begin
				en0_r <= bus_req.wdata & `ICP_EN0_RW_MASK;
			end
			if (wr_en1) begin
				en1_r <= bus_req.wdata & `ICP_LOW6_MASK; // R05
			end
			if (wr_en2) begin
				en2_r <= bus_req.wdata & `ICP_LOW6_MASK; // R03
			end
			if (wr_en3) begin
				en3_r <= bus_req.wdata & `ICP_LOW6_MASK; // R04
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prio_lo_r <= `ICP_RST_BYTE;
			prio_hi_r <= `ICP_RST_BYTE;
		end else begin
			if (wr_lo) begin
				prio_lo_r <= bus_req.wdata & `ICP_LOW6_MASK; // R06
			end
			if (wr_hi) begin
				prio_hi_r <= bus_req.wdata & `ICP_LOW6_MASK; // R06
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sense_r <= `ICP_RST_BYTE;
			pola_r  <= `ICP_RST_BYTE;
			pinen_r <= `ICP_RST_BYTE;
		end else begin
			if (wr_sense) begin
				sense_r <= bus_req.wdata; // R08
			end
			if (wr_pola) begin
				pola_r <= bus_req.wdata;
			end
			if (wr_pinen) begin
				pinen_r <= bus_req.wdata; // R11
			end
		end
	end

	// ----------------------------------------------------------------
	// external pins
	// ----------------------------------------------------------------
	// third stage only remembers the last synchronised level for edges
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_s1 <= 2'h0;
			ext_s2 <= 2'h0;
			ext_s3 <= 2'h0;
		end else begin
			ext_s1 <= ext_pin;         // R16
			ext_s2 <= ext_s1;          // R16
			ext_s3 <= ext_s2;
		end
	end

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			if (sense_r[k]) begin
				cond[k] = pola_r[k] ? (ext_s3[k] && !ext_s2[k]) // R10
				                    : (!ext_s3[k] && ext_s2[k]);
			end else begin
				cond[k] = pola_r[k] ? !ext_s2[k] : ext_s2[k]; // R09
			end
		end
	end

	assign set_ext = cond & pinen_r[1:0]; // R11
	assign ack_clr[0] = irq_ack && irq_vec.valid
	                    && irq_vec.num == `ICP_NUM_EXT0;
	assign ack_clr[1] = irq_ack && irq_vec.valid
	                    && irq_vec.num == `ICP_NUM_EXT1;

	// a new condition wins over a clear in the same cycle
	always_comb begin
		pend_nxt = pend_r;
		if (wr_pend) begin
			pend_nxt = pend_r & bus_req.wdata[1:0]; // R07
		end
		pend_nxt = (pend_nxt & ~ack_clr) | set_ext; // R12 R07
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_r <= 2'h0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	assign en_vec = {en3_r[5:0], en2_r[5:0], en1_r[5:0], en0_r[5:0]}
	              & `ICP_SRC_MASK                        // R02 R03 R04 R05
	              & {24{en0_r[`ICP_GLOBAL_BIT]}};        // R01
	assign req_vec = {periph_req[23:3], pend_r[1], pend_r[0],
	                  periph_req[0]};
	assign pend_vec = req_vec & en_vec; // R17

	// scan from the top so that ties fall to the lower number
	always_comb begin
		best_any = 1'b0;
		best_num = 5'h00;
		best_lvl = 2'h0;
		for (int i = 23; i >= 0; i--) begin
			if (pend_vec[i] &&
			    (!best_any || lvl_of(5'(i), prio_lo_r, prio_hi_r)
			                  >= best_lvl)) begin // R14
				best_any = 1'b1;
				best_num = 5'(i);
				best_lvl = lvl_of(5'(i), prio_lo_r, prio_hi_r);
			end
		end
	end

	assign cur = top_lvl(svc_r);
	assign may_req = best_any && (!cur[2] || best_lvl > cur[1:0]); // R15

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_vec <= '0;
		end else begin
			irq_vec.valid <= may_req && !irq_ack;
			irq_vec.num   <= best_num;
			irq_vec.level <= best_lvl;
		end
	end

	// one in-service bit per level; a return retires the highest
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			svc_r <= 4'h0;
		end else if (irq_ack && irq_vec.valid) begin
			svc_r[irq_vec.level] <= 1'b1; // R15
		end else if (irq_ret && cur[2]) begin
			svc_r[cur[1:0]] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// status and interrupt line
	// ----------------------------------------------------------------
	assign stat_set = {irq_ret, irq_ack && irq_vec.valid,
	                   set_ext[1] && !pend_r[1], set_ext[0] && !pend_r[0]};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_r <= `ICP_RST_STAT;
			mask_r <= `ICP_RST_STAT;
		end else begin
			stat_r <= (stat_r & ~({4{wr_stat}} & bus_req.wdata[3:0]))
			        | stat_set;
			if (wr_mask) begin
				mask_r <= bus_req.wdata[3:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sys_irq <= 1'b0;
		end else begin
			sys_irq <= |(stat_r & mask_r);
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				`ICP_OFS_EN0:     bus_rdata <= en0_r;
				`ICP_OFS_EN1:     bus_rdata <= en1_r;
				`ICP_OFS_EN2:     bus_rdata <= en2_r;
				`ICP_OFS_EN3:     bus_rdata <= en3_r;
				`ICP_OFS_PRIO_LO: bus_rdata <= prio_lo_r;
				`ICP_OFS_PRIO_HI: bus_rdata <= prio_hi_r;
				`ICP_OFS_PEND:    bus_rdata <= {6'h00, pend_r};
				`ICP_OFS_SENSE:   bus_rdata <= sense_r;
				`ICP_OFS_POLA:    bus_rdata <= pola_r;
				`ICP_OFS_PINEN:   bus_rdata <= pinen_r;
				`ICP_OFS_STAT:    bus_rdata <= {4'h0, stat_r};
				`ICP_OFS_MASK:    bus_rdata <= {4'h0, mask_r};
				default:          bus_rdata <= 8'h00;
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	global_off_a: assert property ( // R01
		@(posedge ref_clk) disable iff (rst)
		!en0_r[`ICP_GLOBAL_BIT] |=> !irq_vec.valid)
		else $error("request with global enable off");

	timer_gate_a: assert property ( // R03
		@(posedge ref_clk) disable iff (rst)
		irq_vec.valid && irq_vec.num == 5'h0d |-> $past(en2_r[1]))
		else $error("timer0 request while disabled");

	flag_clear_a: assert property ( // R07
		@(posedge ref_clk) disable iff (rst)
		wr_pend && !bus_req.wdata[0] && !set_ext[0] |=> !pend_r[0])
		else $error("pending flag not cleared by write");

	level_low_a: assert property ( // R09
		@(posedge ref_clk) disable iff (rst)
		!sense_r[0] && pola_r[0] && pinen_r[0] && !ext_s2[0]
		|=> pend_r[0])
		else $error("low level did not set flag");

	rise_edge_a: assert property ( // R10
		@(posedge ref_clk) disable iff (rst)
		sense_r[1] && !pola_r[1] && pinen_r[1] && ext_s2[1] && !ext_s3[1]
		|=> pend_r[1])
		else $error("rising edge did not set flag");

	pin_gate_a: assert property ( // R11
		@(posedge ref_clk) disable iff (rst)
		$rose(pend_r[0]) |-> $past(pinen_r[0]))
		else $error("flag set with pin disabled");

	ack_clear_a: assert property ( // R12
		@(posedge ref_clk) disable iff (rst)
		ack_clr[1] && !set_ext[1] |=> !pend_r[1])
		else $error("taken vector left flag set");

	preempt_lvl_a: assert property ( // R15
		@(posedge ref_clk) disable iff (rst)
		irq_vec.valid && cur[2] |-> irq_vec.level > cur[1:0])
		else $error("request not above running level");

	ext_gate_a: assert property ( // R02 R17
		@(posedge ref_clk) disable iff (rst)
		irq_vec.valid && irq_vec.num == `ICP_NUM_EXT1
		|-> $past(en0_r[2] && pend_r[1]))
		else $error("ext1 request without enable and flag");

	conv_gate_a: assert property ( // R04
		@(posedge ref_clk) disable iff (rst)
		irq_vec.valid && irq_vec.num == 5'h12 |-> $past(en3_r[0]))
		else $error("converter request while disabled");

	empty_group_a: assert property ( // R05
		@(posedge ref_clk) disable iff (rst)
		irq_vec.valid |-> irq_vec.num < 5'h06 || irq_vec.num > 5'h0b)
		else $error("request from a source with no enable");

	edge_hold_a: assert property ( // R08
		@(posedge ref_clk) disable iff (rst)
		sense_r[0] && !pend_r[0] && ext_s2[0] == ext_s3[0] |=> !pend_r[0])
		else $error("edge mode flag set without an edge");

	group_level_a: assert property ( // R06 R13
		@(posedge ref_clk) disable iff (rst)
		irq_vec.valid && irq_vec.num == 5'h0d
		|-> irq_vec.level == $past({prio_hi_r[3], prio_lo_r[3]}))
		else $error("timer0 level not from group three");

	irq_line_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		##1 sys_irq == $past(|(stat_r & mask_r)))
		else $error("interrupt line mismatch");

endmodule : icp_ctrl

`default_nettype wire

// ---- bench/icp_core_model.sv ----
// behavioural processor core that takes the vector it is shown
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// core model
// ----------------------------------------------------------------
module icp_core_model (
	input  wire logic                 ref_clk, // system clock
	input  wire logic                 rst,     // async reset, high
	input  wire icp_pkg::icp_vec_type irq_vec, // request from the block
	input  wire logic                 ack_en,  // take the next vector
	output var  logic                 irq_ack  // vector taken
);
	// one pulse, and only while a vector stands: a dropped one is never taken
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_ack <= 1'b0;
		end else begin
			irq_ack <= ack_en & irq_vec.valid & ~irq_ack;
		end
	end
endmodule : icp_core_model
`default_nettype wire

// ---- bench/interrupt_enable_priority_extint_bench.sv ----
// self-checking bench of the interrupt enable and priority block
`include "icp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_priority_extint_bench;
	logic                 ref_clk = 1'b0;
	logic                 rst = 1'b1;
	icp_pkg::icp_bus_type bus_req = '0;
	logic [7:0]           bus_rdata;
	logic [1:0]           ext_pin = 2'b00;
	logic [23:0]          periph_req = '0;
	logic [23:0]          q;
	logic                 irq_ret = 1'b0;
	logic                 ack_en = 1'b0;
	logic                 irq_ack;
	icp_pkg::icp_vec_type irq_vec;
	logic                 sys_irq;
	integer               seed = 32'hb4421c42;
	int                   n_mismatch = 0;
	int                   n_checks = 0;
	int                   cyc = 0;
	logic [7:0]           d, e, lo, hi, r0, r1, r2, r3;
	logic [7:0]           ofs [12] = '{`ICP_OFS_EN0, `ICP_OFS_EN1,
		`ICP_OFS_EN2, `ICP_OFS_EN3, `ICP_OFS_PEND, `ICP_OFS_SENSE,
		`ICP_OFS_POLA, `ICP_OFS_PINEN, `ICP_OFS_PRIO_LO,
		`ICP_OFS_PRIO_HI, `ICP_OFS_STAT, `ICP_OFS_MASK};

	always #12.5 ref_clk = ~ref_clk;

	icp_ctrl icp_ctrl_i (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .ext_pin(ext_pin), .periph_req(periph_req),
		.irq_ack(irq_ack), .irq_ret(irq_ret), .irq_vec(irq_vec),
		.sys_irq(sys_irq));
	icp_core_model icp_core_model_i (.ref_clk(ref_clk), .rst(rst),
		.irq_vec(irq_vec), .ack_en(ack_en), .irq_ack(irq_ack));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	task automatic clk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : clk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		#1 v = bus_rdata;
	endtask : rd

	task automatic take;
		@(posedge ref_clk);
		ack_en <= 1'b1;
		@(posedge ref_clk);
		ack_en <= 1'b0;
		clk(3);
	endtask : take

	task automatic retire;
		@(posedge ref_clk);
		irq_ret <= 1'b1;
		@(posedge ref_clk);
		irq_ret <= 1'b0;
		clk(2);
	endtask : retire

	// best request above the running level; lowest number wins a tie
	function automatic logic [7:0] best(input int run);
		int         bl;
		logic [4:0] bn;
		logic [1:0] l;
		bl = -1;
		bn = 5'h00;
		for (int n = 0; n < 24; n++) begin
			l = {hi[n / 4], lo[n / 4]};
			if (q[n] && int'(l) > bl) begin
				bl = l;
				bn = n[4:0];
			end
		end
		return {bl > run, bn, bl[1:0]};
	endfunction : best

	// num and level are only compared while a vector stands
	task automatic vchk(input logic [7:0] x);
		if (x[7]) begin
			chk(irq_vec, x);
		end else begin
			chk({7'h00, irq_vec.valid}, 8'h00);
		end
	endtask : vchk

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (ofs[i]) begin
			rd(ofs[i], d);
			chk(d, 8'h00);
		end
		rd(8'h00, d);
		chk(d, 8'h00);
		wr(`ICP_OFS_EN0, 8'hff);
		rd(`ICP_OFS_EN0, d);
		chk(d, `ICP_EN0_RW_MASK);
		for (int i = 1; i < 10; i++) begin
			if (i < 4 || i > 7) begin
				e = 8'($random(seed));
				wr(ofs[i], e);
				rd(ofs[i], d);
				chk(d, e & `ICP_LOW6_MASK);
				wr(ofs[i], 8'h00);
			end
		end
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		chk(d, 8'h00);
		wr(`ICP_OFS_EN0, 8'h00);
		lo = 8'h00;
		hi = 8'h00;
		// ext0 in all four sense and polarity modes; ext1 pin enable stays off
		wr(`ICP_OFS_PINEN, 8'h01);
		for (int m = 0; m < 4; m++) begin
			wr(`ICP_OFS_SENSE, {7'h00, m[1]});
			wr(`ICP_OFS_POLA, {7'h00, m[0]});
			ext_pin <= {2{m[0]}};
			clk(4);
			wr(`ICP_OFS_PEND, 8'h00);
			rd(`ICP_OFS_PEND, d);
			chk(d, 8'h00);
			ext_pin <= {2{~m[0]}};
			clk(4);
			rd(`ICP_OFS_PEND, d);
			chk(d, 8'h01);
			if (m == 3) begin
				wr(`ICP_OFS_EN0, 8'h82);
				clk(2);
				vchk({1'b1, `ICP_NUM_EXT0, 2'b00});
				take();
				rd(`ICP_OFS_PEND, d);
				chk(d, 8'h00);
				vchk(8'h00);
				retire();
				wr(`ICP_OFS_EN0, 8'h00);
			end else begin
				wr(`ICP_OFS_PEND, 8'h00);
				rd(`ICP_OFS_PEND, d);
				chk(d, m[1] ? 8'h00 : 8'h01);
			end
		end
		wr(`ICP_OFS_PINEN, 8'h00);
		wr(`ICP_OFS_PEND, 8'h00);
		// random enables, levels and requests
		for (int i = 0; i < 24; i++) begin
			lo = 8'($random(seed));
			hi = 8'($random(seed));
			r0 = 8'($random(seed));
			r0[7] = (i % 4 != 0);
			r1 = 8'($random(seed));
			r2 = 8'($random(seed)) | {8{i[0]}};
			r3 = 8'($random(seed)) | {8{i[0]}};
			wr(`ICP_OFS_EN0, r0);
			wr(`ICP_OFS_EN1, r1);
			wr(`ICP_OFS_EN2, r2);
			wr(`ICP_OFS_EN3, r3);
			wr(`ICP_OFS_PRIO_LO, lo);
			wr(`ICP_OFS_PRIO_HI, hi);
			periph_req <= 24'($random(seed));
			clk(4);
			q = periph_req & 24'h646000 & {24{r0[7]}}
				& {r3[5:0], r2[5:0], r1[5:0], r0[5:0]};
			e = best(-1);
			vchk(e);
			if (e[7]) begin
				take();
				vchk(best(e[1:0]));
				retire();
			end
			periph_req <= '0;
		end
		// preemption ladder: level 0 runs, level 2 breaks in, equal waits
		wr(`ICP_OFS_EN0, 8'h80);
		wr(`ICP_OFS_EN1, 8'h00);
		wr(`ICP_OFS_EN2, 8'h06);
		wr(`ICP_OFS_EN3, 8'h19);
		wr(`ICP_OFS_PRIO_LO, 8'h00);
		wr(`ICP_OFS_PRIO_HI, 8'h00);
		periph_req <= 24'h400000;
		clk(4);
		vchk({1'b1, 5'h16, 2'b00});
		take();
		wr(`ICP_OFS_PRIO_HI, 8'h18);
		periph_req <= 24'h442000;
		clk(4);
		vchk({1'b1, 5'h0d, 2'b10});
		take();
		vchk(8'h00);
		retire();
		vchk({1'b1, 5'h0d, 2'b10});
		retire();
		periph_req <= '0;
		// status events against the mask
		rd(`ICP_OFS_STAT, d);
		chk(d, 8'h0d);
		chk({7'h00, sys_irq}, 8'h00);
		wr(`ICP_OFS_MASK, 8'h04);
		clk(2);
		chk({7'h00, sys_irq}, 8'h01);
		wr(`ICP_OFS_STAT, 8'h04);
		clk(2);
		chk({7'h00, sys_irq}, 8'h00);
		rd(`ICP_OFS_STAT, d);
		chk(d, 8'h09);
		// reset in mid-run returns enable 3, status and the request to the core to zero
		rst <= 1'b1;
		clk(3);
		rst <= 1'b0;
		rd(`ICP_OFS_EN3, d);
		chk(d, 8'h00);
		rd(`ICP_OFS_STAT, d);
		chk(d, 8'h00);
		chk({7'h00, irq_vec.valid}, 8'h00);
		end_of_test();
	end
endmodule : interrupt_enable_priority_extint_bench
`default_nettype wire
